// ===== design/moc_pkg.sv
// Shared constants and carriers for the main oscillator control block, and
// the main clock frequency meter that the top module instantiates.
// Assumes one 10 MHz system clock; slow and main clocks arrive as pins.
//
// Functional notes
// - Crystal oscillator off and unselected after reset.
// - Enable bit turns crystal oscillator on/off.
// - Clearing enable clears the stabilized flag.
// - Enabling write clears flag, loads startup down-counter.
// - Counter reaching zero sets stabilized flag.
// - Masked stabilized flag raises interrupt request.
// - Restart bit begins a fresh frequency measurement.
// - Extra read after ready returns measured count.
// - Count main clock edges over 16 slow cycles.
// - Glitch-free source switch with switch-done flag.

`timescale 1ns/1ps

package moc_pkg;

  localparam int unsigned STARTUP_W      = 8;
  localparam int unsigned PRESCALE_W     = 3;
  localparam logic [2:0]  PRESCALE_LAST  = 3'h7;
  localparam int unsigned MEAS_W         = 16;
  localparam logic [4:0]  MEAS_WINDOW    = 5'h10;
  localparam int unsigned TRIM_W         = 7;
  localparam logic [6:0]  TRIM_RESET     = 7'h40;
  localparam logic [1:0]  SWITCH_EDGES   = 2'h2;
  localparam logic        XTAL_EN_RESET  = 1'h0;
  localparam logic        SRC_SEL_RESET  = 1'h0;

  typedef struct packed {
    logic                 xtal_osc_enable;
    logic [STARTUP_W-1:0] xtal_startup_count;
    logic                 main_source_choice;
  } moc_ctrl_t;

  typedef struct packed {
    logic xtal_stabilized_flag;
    logic main_source_switch_done;
    logic freq_measure_ready;
  } moc_status_t;

  typedef enum logic [3:0] {
    MEAS_ARM   = 4'h1,
    MEAS_COUNT = 4'h2,
    MEAS_DONE  = 4'h4,
    MEAS_IDLE  = 4'h8
  } moc_meas_state_t;

endpackage : moc_pkg

// Counts main clock edges inside a window of slow clock edges. Both edge
// inputs are single-cycle pulses already synchronised by the caller.
module moc_freq_meter (
  input  wire logic                      mclk_in,
  input  wire logic                      rst_in,
  input  wire logic                      slow_edge_in,
  input  wire logic                      main_edge_in,
  input  wire logic                      restart_in,
  output logic                           ready_out,
  output logic [moc_pkg::MEAS_W-1:0]     count_out
);

  moc_pkg::moc_meas_state_t   state_q, state_d;
  logic [4:0]                 win_q, win_d;
  logic [moc_pkg::MEAS_W-1:0] cnt_q, cnt_d;

  always_comb begin
    state_d = state_q;
    win_d   = win_q;
    cnt_d   = cnt_q;
    if (restart_in) begin
      state_d = moc_pkg::MEAS_ARM;
    end else begin
      unique case (state_q)
        moc_pkg::MEAS_ARM: begin
          // The window opens on a slow edge so it spans whole periods.
          if (slow_edge_in) begin
            state_d = moc_pkg::MEAS_COUNT;
            win_d   = 5'h0;
            cnt_d   = '0;
          end
        end
        moc_pkg::MEAS_COUNT: begin
          if (main_edge_in && cnt_q != '1) begin
            cnt_d = cnt_q + 1'b1;
          end
          if (slow_edge_in) begin
            win_d = win_q + 1'b1;
            if (win_q + 5'h1 == moc_pkg::MEAS_WINDOW) begin
              state_d = moc_pkg::MEAS_DONE;
            end
          end
        end
        moc_pkg::MEAS_DONE: begin
          state_d = moc_pkg::MEAS_IDLE;
        end
        moc_pkg::MEAS_IDLE: begin
          state_d = moc_pkg::MEAS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= moc_pkg::MEAS_ARM;
      win_q   <= 5'h0;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      win_q   <= win_d;
      cnt_q   <= cnt_d;
    end
  end

  assign ready_out = (state_q == moc_pkg::MEAS_DONE) ||
                     (state_q == moc_pkg::MEAS_IDLE);
  assign count_out = cnt_q;

endmodule : moc_freq_meter

// ===== design/moc_main_osc_ctrl.sv
// Main oscillator control: crystal enable and startup countdown, main
// source switching, frequency measurement result and RC trim output.
// Assumes control writes arrive as one-cycle strobes on the 10 MHz clock
// and that slow_clock_in and main_clock_in are asynchronous pins.

`timescale 1ns/1ps

module moc_main_osc_ctrl (
  input  wire logic                         mclk_in,
  input  wire logic                         rst_in,
  input  wire logic                         ctrl_write_in,
  input  wire moc_pkg::moc_ctrl_t           ctrl_in,
  input  wire moc_pkg::moc_status_t         irq_mask_in,
  input  wire logic                         freq_measure_restart_in,
  input  wire logic                         freq_reg_read_in,
  input  wire logic                         rc_trim_select_in,
  input  wire logic [moc_pkg::TRIM_W-1:0]   rc_trim_value_in,
  input  wire logic                         slow_clock_in,
  input  wire logic                         main_clock_in,
  output logic                              xtal_osc_on_out,
  output logic                              main_source_xtal_out,
  output moc_pkg::moc_status_t              status_out,
  output logic [moc_pkg::MEAS_W-1:0]        measured_freq_count_out,
  output logic [moc_pkg::TRIM_W-1:0]        rc_trim_out,
  output logic                              irq_out
);

  // Two-stage synchronisers plus one history stage for edge detection.
  logic [2:0] slow_sync_q;
  logic [2:0] main_sync_q;
  logic       slow_edge;
  logic       main_edge;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      slow_sync_q <= 3'h0;
      main_sync_q <= 3'h0;
    end else begin
      slow_sync_q <= {slow_sync_q[1:0], slow_clock_in};
      main_sync_q <= {main_sync_q[1:0], main_clock_in};
    end
  end

  assign slow_edge = slow_sync_q[1] & ~slow_sync_q[2];
  assign main_edge = main_sync_q[1] & ~main_sync_q[2];

  // Crystal enable, startup countdown and stabilized flag.
  logic                          xen_q, xen_d;
  logic [moc_pkg::STARTUP_W-1:0] start_cnt_q, start_cnt_d;
  logic [moc_pkg::PRESCALE_W-1:0] pre_q, pre_d;
  logic                          counting_q, counting_d;
  logic                          stab_q, stab_d;

  always_comb begin
    xen_d       = xen_q;
    start_cnt_d = start_cnt_q;
    pre_d       = pre_q;
    counting_d  = counting_q;
    stab_d      = stab_q;
    if (ctrl_write_in) begin
      xen_d = ctrl_in.xtal_osc_enable;
      if (!ctrl_in.xtal_osc_enable) begin
        stab_d     = 1'b0;
        counting_d = 1'b0;
      end else begin
        // A write that keeps the crystal enabled restarts the countdown.
        stab_d      = 1'b0;
        start_cnt_d = ctrl_in.xtal_startup_count;
        pre_d       = '0;
        counting_d  = 1'b1;
      end
    end else if (counting_q) begin
      // A startup count of zero sets the flag on the very next cycle.
      if (start_cnt_q == '0) begin
        stab_d     = 1'b1;
        counting_d = 1'b0;
      end else if (slow_edge) begin
        pre_d = pre_q + 1'b1;
        if (pre_q == moc_pkg::PRESCALE_LAST) begin
          start_cnt_d = start_cnt_q - 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      xen_q       <= moc_pkg::XTAL_EN_RESET;
      start_cnt_q <= '0;
      pre_q       <= '0;
      counting_q  <= 1'b0;
      stab_q      <= 1'b0;
    end else begin
      xen_q       <= xen_d;
      start_cnt_q <= start_cnt_d;
      pre_q       <= pre_d;
      counting_q  <= counting_d;
      stab_q      <= stab_d;
    end
  end

  // Main source switch. The new source takes effect only after two slow
  // clock edges, so the mux never changes inside a short output pulse.
  // The crystal is only taken once it is stabilized; a request made before
  // that waits, and a disabled crystal forces the RC source back.
  logic       choice_q, choice_d;
  logic       sel_q, sel_d;
  logic [1:0] dwell_q, dwell_d;
  logic       done_q, done_d;
  logic       want_xtal;

  assign want_xtal = choice_q & stab_q & xen_q;

  always_comb begin
    choice_d = choice_q;
    sel_d    = sel_q;
    dwell_d  = dwell_q;
    done_d   = done_q;
    if (ctrl_write_in) begin
      choice_d = ctrl_in.main_source_choice;
    end
    if (want_xtal == sel_q) begin
      dwell_d = 2'h0;
      done_d  = 1'b1;
    end else begin
      done_d = 1'b0;
      if (slow_edge) begin
        dwell_d = dwell_q + 1'b1;
        if (dwell_q + 2'h1 == moc_pkg::SWITCH_EDGES) begin
          sel_d   = want_xtal;
          dwell_d = 2'h0;
        end
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      choice_q <= moc_pkg::SRC_SEL_RESET;
      sel_q    <= moc_pkg::SRC_SEL_RESET;
      dwell_q  <= 2'h0;
      done_q   <= 1'b1;
    end else begin
      choice_q <= choice_d;
      sel_q    <= sel_d;
      dwell_q  <= dwell_d;
      done_q   <= done_d;
    end
  end

  // Frequency measurement and the read-back that exposes its result.
  logic                        meas_ready;
  logic [moc_pkg::MEAS_W-1:0]  meas_count;
  logic                        seen_ready_q, seen_ready_d;
  logic [moc_pkg::MEAS_W-1:0]  shown_q, shown_d;

  moc_freq_meter u_meter (
    .mclk_in      (mclk_in),
    .rst_in       (rst_in),
    .slow_edge_in (slow_edge),
    .main_edge_in (main_edge),
    .restart_in   (freq_measure_restart_in),
    .ready_out    (meas_ready),
    .count_out    (meas_count)
  );

  always_comb begin
    seen_ready_d = seen_ready_q;
    shown_d      = shown_q;
    if (freq_measure_restart_in) begin
      seen_ready_d = 1'b0;
    end else if (freq_reg_read_in && meas_ready) begin
      // The first read that sees ready only arms; the next one updates.
      if (seen_ready_q) begin
        shown_d = meas_count;
      end
      seen_ready_d = 1'b1;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      seen_ready_q <= 1'b0;
      shown_q      <= '0;
    end else begin
      seen_ready_q <= seen_ready_d;
      shown_q      <= shown_d;
    end
  end

  // RC trim: the programmed value applies only while select is set.
  logic [moc_pkg::TRIM_W-1:0] trim_q, trim_d;

  always_comb begin
    trim_d = moc_pkg::TRIM_RESET;
    if (rc_trim_select_in) begin
      trim_d = rc_trim_value_in;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      trim_q <= moc_pkg::TRIM_RESET;
    end else begin
      trim_q <= trim_d;
    end
  end

  // Outputs.
  assign xtal_osc_on_out                    = xen_q;
  assign main_source_xtal_out               = sel_q;
  // One assignment drives the whole status word, so it has a single driver.
  assign status_out = '{
    xtal_stabilized_flag:    stab_q,
    main_source_switch_done: done_q,
    freq_measure_ready:      meas_ready
  };
  assign measured_freq_count_out            = shown_q;
  assign rc_trim_out                        = trim_q;
  assign irq_out = |(status_out & irq_mask_in);

endmodule : moc_main_osc_ctrl

// ===== bench/moc_ctrl_asserts.sv
// Checker for the main oscillator control block, bound to its top module.
// Assumes moc_pkg is compiled first; sees only the top module's ports.
`timescale 1ns/1ps
module moc_ctrl_asserts (
  input wire logic                        mclk_in,
  input wire logic                        rst_in,
  input wire logic                        ctrl_write_in,
  input wire moc_pkg::moc_ctrl_t          ctrl_in,
  input wire moc_pkg::moc_status_t        irq_mask_in,
  input wire logic                        freq_measure_restart_in,
  input wire logic                        rc_trim_select_in,
  input wire logic [moc_pkg::TRIM_W-1:0]  rc_trim_value_in,
  input wire logic                        xtal_osc_on_out,
  input wire logic                        main_source_xtal_out,
  input wire moc_pkg::moc_status_t        status_out,
  input wire logic [moc_pkg::TRIM_W-1:0]  rc_trim_out,
  input wire logic                        irq_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  reset_off_a: assert property
    ($fell(rst_in) |-> !xtal_osc_on_out && !main_source_xtal_out)
    else $error("crystal active out of reset");
  enable_follow_a: assert property
    (ctrl_write_in |=> xtal_osc_on_out == $past(ctrl_in.xtal_osc_enable))
    else $error("enable output ignores write");
  stab_clear_a: assert property
    (ctrl_write_in |=> !status_out.xtal_stabilized_flag)
    else $error("stable flag not cleared by write");
  stab_cause_a: assert property
    ($rose(status_out.xtal_stabilized_flag) |-> xtal_osc_on_out)
    else $error("stable flag set with crystal off");
  irq_match_a: assert property
    (irq_out == |(status_out & irq_mask_in))
    else $error("interrupt differs from masked status");
  restart_clear_a: assert property
    (freq_measure_restart_in |=> !status_out.freq_measure_ready)
    else $error("ready kept after restart");
  ready_hold_a: assert property
    (status_out.freq_measure_ready && !freq_measure_restart_in
      |=> status_out.freq_measure_ready)
    else $error("ready dropped without restart");
  switch_done_a: assert property
    ($changed(main_source_xtal_out)
      |-> !status_out.main_source_switch_done
      ##1 status_out.main_source_switch_done)
    else $error("switch done flag wrong around switch");
  xtal_gate_a: assert property
    ($rose(main_source_xtal_out) |-> status_out.xtal_stabilized_flag)
    else $error("switched to unstable crystal");
  trim_map_a: assert property
    (rc_trim_out == ($past(rc_trim_select_in) ? $past(rc_trim_value_in)
      : moc_pkg::TRIM_RESET))
    else $error("trim output wrong");
endmodule : moc_ctrl_asserts

bind moc_main_osc_ctrl moc_ctrl_asserts u_chk (.mclk_in, .rst_in,
  .ctrl_write_in, .ctrl_in, .irq_mask_in, .freq_measure_restart_in,
  .rc_trim_select_in, .rc_trim_value_in, .xtal_osc_on_out,
  .main_source_xtal_out, .status_out, .rc_trim_out, .irq_out);

// ===== bench/test_moc_main_osc_ctrl.sv
// Self-checking bench for the main oscillator control block.
// Assumes the design and the bound checker are compiled before it.
`timescale 1ns/1ps
module test_moc_main_osc_ctrl;
  logic mclk_in = 1'h0, rst_in = 1'h1, wr = 1'h0, rs = 1'h0, rd = 1'h0;
  logic tsel = 1'h0, slow = 1'h0, main = 1'h0, on, srcx, irq;
  logic [6:0] tval = 7'h15;
  logic [6:0] trim;
  logic [15:0] cnt;
  logic [3:0] flags;
  moc_pkg::moc_ctrl_t ctrl = '0;
  moc_pkg::moc_status_t mask = '0;
  moc_pkg::moc_status_t st;
  int bad_count = 0;
  int check_count = 0;
  assign flags = {srcx, st};
  moc_main_osc_ctrl dut (.mclk_in(mclk_in), .rst_in(rst_in),
    .ctrl_write_in(wr), .ctrl_in(ctrl), .irq_mask_in(mask),
    .freq_measure_restart_in(rs), .freq_reg_read_in(rd),
    .rc_trim_select_in(tsel), .rc_trim_value_in(tval),
    .slow_clock_in(slow), .main_clock_in(main), .xtal_osc_on_out(on),
    .main_source_xtal_out(srcx), .status_out(st),
    .measured_freq_count_out(cnt), .rc_trim_out(trim), .irq_out(irq));
  always #50 mclk_in = ~mclk_in;
  // Four main periods fit in each slow period, so a window holds 64 edges.
  initial begin
    #30;
    forever #800 slow = ~slow;
  end
  initial begin
    #80;
    forever #200 main = ~main;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #10;
  endtask : tick
  task automatic wait_flag(input int i, input logic v, output int n);
    n = 0;
    while (flags[i] !== v && n < 2000) begin
      tick(1);
      n++;
    end
  endtask : wait_flag
  task automatic pulse_write(input moc_pkg::moc_ctrl_t c);
    ctrl = c;
    wr = 1'h1;
    tick(1);
    wr = 1'h0;
  endtask : pulse_write
  task automatic t_reset();
    check({on, srcx}, 16'h0);
    check(st, 16'h2);
    check({irq, cnt[7:0], trim}, 16'h40);
    $display("test reset done");
  endtask : t_reset
  task automatic t_startup();
    int n;
    mask = 3'h4;
    pulse_write('{1'h1, 8'h02, 1'h1});
    check({on, st[2]}, 16'h2);
    wait_flag(2, 1'h1, n);
    // Two counts of eight slow periods each: 256 cycles plus phase.
    check(n > 240 && n < 280, 16'h1);
    check(irq, 16'h1);
    mask = 3'h0;
    tick(1);
    check(irq, 16'h0);
    wait_flag(3, 1'h1, n);
    check(n < 80, 16'h1);
    tick(1);
    check(st[1], 16'h1);
    $display("test startup done");
  endtask : t_startup
  task automatic t_disable();
    int n;
    pulse_write('{1'h0, 8'h00, 1'h1});
    check({on, st[2]}, 16'h0);
    wait_flag(3, 1'h0, n);
    tick(1);
    check({n < 80, st[1]}, 16'h3);
    $display("test disable done");
  endtask : t_disable
  task automatic t_measure();
    int n;
    rs = 1'h1;
    tick(1);
    rs = 1'h0;
    check(st[0], 16'h0);
    wait_flag(0, 1'h1, n);
    check(n > 250 && n < 290, 16'h1);
    rd = 1'h1;
    tick(1);
    rd = 1'h0;
    tick(1);
    check(cnt, 16'h0);
    rd = 1'h1;
    tick(1);
    rd = 1'h0;
    tick(1);
    check(cnt, 16'h40);
    $display("test measure done");
  endtask : t_measure
  task automatic t_trim();
    tick(2);
    check(trim, 16'h40);
    tsel = 1'h1;
    tick(2);
    check(trim, 16'h15);
    $display("test trim done");
  endtask : t_trim
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (8) @(posedge mclk_in);
    #10;
    rst_in = 1'h0;
    tick(2);
    t_reset();
    t_startup();
    t_disable();
    t_measure();
    t_trim();
    summarize();
  end
  // The whole sequence needs about 620 cycles; over six times that is a hang.
  initial begin
    #(4000 * 100);
    bad_count++;
    summarize();
  end
endmodule : test_moc_main_osc_ctrl
